//--- sie_avm_master.sv
// Processor side bus master that issues one command per go pulse.
`timescale 1ns/1ps
`default_nettype none
module sie_avm_master (
	input wire logic                 clk,
	input wire logic                 go,
	input wire sie_pkg::sie_avm_req_s cmd,
	input wire logic                 waitrequest,
	input wire logic [31:0]          readdata,
	input wire logic [1:0]           response,
	output sie_pkg::sie_avm_req_s    bus,
	output logic                     done,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp
);
	initial bus = '0;
	initial done = 1'b0;
	// Released lines show inverted values so stale data can never pass.
	always @(posedge clk) begin
		done <= (bus.read || bus.write) && !waitrequest;
		if (!(bus.read || bus.write) && go)
			bus <= cmd;
		if ((bus.read || bus.write) && !waitrequest) begin
			rdata <= readdata;
			rresp <= response;
			bus <= '{address: ~bus.address, read: 1'b0, write: 1'b0,
				byteenable: ~bus.byteenable, writedata: ~bus.writedata};
		end
	end
endmodule // sie_avm_master
`default_nettype wire

//--- sie_defines.svh
// Register offsets, field positions and reset values of the interrupt enable block.
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define SIE_OFS_EN_CLR     4'h0
`define SIE_OFS_EN_SET     4'h4
`define SIE_OFS_FLAGS      4'h8
`define SIE_OFS_PENDING    4'hC
`define SIE_ADDR_W         4

// ==========================================================================
// Enable and flag bit positions
`define SIE_BIT_XTAL_RDY        0
`define SIE_BIT_XTAL32K_RDY     1
`define SIE_BIT_RC32K_RDY       2
`define SIE_BIT_RC8M_RDY        3
`define SIE_BIT_FLL_RDY         4
`define SIE_BIT_FLL_OOB         5
`define SIE_BIT_FLL_FINE        6
`define SIE_BIT_FLL_COARSE      7
`define SIE_BIT_FLL_REFSTOP     8
`define SIE_BIT_BOD_RDY         9
`define SIE_BIT_BOD_DET         10
`define SIE_BIT_BOD_SYNC_RDY    11
`define SIE_BIT_PLL_LOCK_RISE   15
`define SIE_BIT_PLL_LOCK_FALL   16
`define SIE_BIT_PLL_LOCK_TO     17

// ==========================================================================
// Widths, masks and reset values
`define SIE_NUM_SRC        18
`define SIE_IMPL_MASK      32'h0003_8FFF
`define SIE_EN_RESET       32'h0000_0000
`define SIE_FLAG_RESET     32'h0000_0000
`define SIE_RDATA_RESET    32'h0000_0000
`define SIE_RESP_OKAY      2'h0
`define SIE_RESP_SLVERR    2'h2
`define SIE_RESP_DECERR    2'h3

`endif

//--- sie_irq_enable_clear.sv
// Interrupt enable mask, flags and request logic of the system controller.
`timescale 1ns/1ps
`default_nettype none
`include "sie_defines.svh"

module sie_irq_enable_clear (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic [`SIE_ADDR_W-1:0]    avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [3:0]                avs_byteenable,
	input  wire logic [31:0]               avs_writedata,
	output logic                           avs_waitrequest,
	output logic [31:0]                    avs_readdata,
	output logic [1:0]                     avs_response,
	input  wire logic                      write_lock,
	input  wire logic [`SIE_NUM_SRC-1:0]   src_level,
	output logic                           irq
);

	// ======================================================================
	// Reset release
	logic rst_meta_r;
	logic rst_n_r;

	// The release is synchronised so no flop leaves reset on a split edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ======================================================================
	// Request bundle
	sie_pkg::sie_avm_req_s req;

	assign req.address    = avs_address;
	assign req.read       = avs_read;
	assign req.write      = avs_write;
	assign req.byteenable = avs_byteenable;
	assign req.writedata  = avs_writedata;

	// ======================================================================
	// Source event capture
	// Sources live on their own clocks, so each implemented level passes two flops and
	// only the second stage and its delayed copy feed the edge detector.
	logic [31:0] src_meta_r;
	logic [31:0] src_sync_r;
	logic [31:0] src_prev_r;
	logic [31:0] src_rise;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_src
			if (gi < `SIE_NUM_SRC && ((`SIE_IMPL_MASK >> gi) & 1) != 0) begin : g_impl
				logic meta_r;
				logic sync_r;
				logic prev_r;

				// Only the second stage and its delayed copy are read; the first may still be settling.
				always_ff @(posedge clk or negedge rst_n_r) begin
					if (!rst_n_r) begin
						meta_r <= 1'b0;
						sync_r <= 1'b0;
						prev_r <= 1'b0;
					end else begin
						meta_r <= src_level[gi];
						sync_r <= meta_r;
						prev_r <= sync_r;
					end
				end

				assign src_meta_r[gi] = meta_r;
				assign src_sync_r[gi] = sync_r;
				assign src_prev_r[gi] = prev_r;
				assign src_rise[gi]   = sync_r & ~prev_r;
			end else begin : g_none
				assign src_meta_r[gi] = 1'b0;
				assign src_sync_r[gi] = 1'b0;
				assign src_prev_r[gi] = 1'b0;
				assign src_rise[gi]   = 1'b0;
			end
		end
	endgenerate

	// ======================================================================
	// Bus sequencer
	sie_pkg::sie_bus_state_e state_r;
	sie_pkg::sie_bus_state_e state_nxt;
	sie_pkg::sie_avm_rsp_s   rsp_r;
	sie_pkg::sie_avm_rsp_s   rsp_nxt;
	logic [31:0]             en_r;
	logic [31:0]             flag_r;
	logic                    hit_clr;
	logic                    hit_set;
	logic                    hit_flag;
	logic                    hit_pend;
	logic                    mapped;
	logic                    commit;
	logic [31:0]             lane_mask;
	logic [31:0]             wr_ones;

	always_comb begin
		hit_clr   = (req.address == `SIE_OFS_EN_CLR);
		hit_set   = (req.address == `SIE_OFS_EN_SET);
		hit_flag  = (req.address == `SIE_OFS_FLAGS);
		hit_pend  = (req.address == `SIE_OFS_PENDING);
		mapped    = hit_clr | hit_set | hit_flag | hit_pend;
		lane_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
			{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
		wr_ones   = req.writedata & lane_mask & `SIE_IMPL_MASK;
		// A write takes effect only on the edge that sees waitrequest low.
		commit    = (state_r == sie_pkg::SIE_ST_ANSWER) & req.write & mapped
			& ~write_lock & ~hit_pend;
	end

	always_comb begin
		state_nxt           = state_r;
		rsp_nxt             = rsp_r;
		rsp_nxt.waitrequest = 1'b1;
		unique case (state_r)
			sie_pkg::SIE_ST_IDLE: begin
				if (req.read || req.write) begin
					state_nxt           = sie_pkg::SIE_ST_ANSWER;
					rsp_nxt.waitrequest = 1'b0;
					rsp_nxt.readdata    = `SIE_RDATA_RESET;
					rsp_nxt.response    = `SIE_RESP_OKAY;
					if (!mapped) begin
						rsp_nxt.response = `SIE_RESP_DECERR;
					end else if (req.write && (write_lock || hit_pend)) begin
						rsp_nxt.response = `SIE_RESP_SLVERR;
					end else if (req.read) begin
						if (hit_clr || hit_set) begin
							rsp_nxt.readdata = en_r;
						end else if (hit_flag) begin
							rsp_nxt.readdata = flag_r;
						end else begin
							rsp_nxt.readdata = flag_r & en_r;
						end
					end
				end
			end
			sie_pkg::SIE_ST_ANSWER: begin
				state_nxt = sie_pkg::SIE_ST_IDLE;
			end
			default: begin
				state_nxt = sie_pkg::SIE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r             <= sie_pkg::SIE_ST_IDLE;
			rsp_r.waitrequest   <= 1'b1;
			rsp_r.readdata      <= `SIE_RDATA_RESET;
			rsp_r.response      <= `SIE_RESP_OKAY;
		end else begin
			state_r <= state_nxt;
			rsp_r   <= rsp_nxt;
		end
	end

	// ======================================================================
	// Enable mask
	logic [31:0] en_nxt;
	logic [31:0] clr_hit;
	logic [31:0] set_hit;
	logic        clr_wr;
	logic        set_wr;

	// Each implemented source has its own clear strobe, so a one written to a
	// reserved position can never reach an enable flop.
	always_comb begin
		clr_wr  = commit & hit_clr;
		set_wr  = commit & hit_set;
		clr_hit = 32'h0000_0000;
		clr_hit[`SIE_BIT_XTAL_RDY]      = clr_wr & wr_ones[`SIE_BIT_XTAL_RDY];
		clr_hit[`SIE_BIT_XTAL32K_RDY]   = clr_wr & wr_ones[`SIE_BIT_XTAL32K_RDY];
		clr_hit[`SIE_BIT_RC32K_RDY]     = clr_wr & wr_ones[`SIE_BIT_RC32K_RDY];
		clr_hit[`SIE_BIT_RC8M_RDY]      = clr_wr & wr_ones[`SIE_BIT_RC8M_RDY];
		clr_hit[`SIE_BIT_FLL_RDY]       = clr_wr & wr_ones[`SIE_BIT_FLL_RDY];
		clr_hit[`SIE_BIT_FLL_OOB]       = clr_wr & wr_ones[`SIE_BIT_FLL_OOB];
		clr_hit[`SIE_BIT_FLL_FINE]      = clr_wr & wr_ones[`SIE_BIT_FLL_FINE];
		clr_hit[`SIE_BIT_FLL_COARSE]    = clr_wr & wr_ones[`SIE_BIT_FLL_COARSE];
		clr_hit[`SIE_BIT_FLL_REFSTOP]   = clr_wr & wr_ones[`SIE_BIT_FLL_REFSTOP];
		clr_hit[`SIE_BIT_BOD_RDY]       = clr_wr & wr_ones[`SIE_BIT_BOD_RDY];
		clr_hit[`SIE_BIT_BOD_DET]       = clr_wr & wr_ones[`SIE_BIT_BOD_DET];
		clr_hit[`SIE_BIT_BOD_SYNC_RDY]  = clr_wr & wr_ones[`SIE_BIT_BOD_SYNC_RDY];
		clr_hit[`SIE_BIT_PLL_LOCK_RISE] = clr_wr & wr_ones[`SIE_BIT_PLL_LOCK_RISE];
		clr_hit[`SIE_BIT_PLL_LOCK_FALL] = clr_wr & wr_ones[`SIE_BIT_PLL_LOCK_FALL];
		clr_hit[`SIE_BIT_PLL_LOCK_TO]   = clr_wr & wr_ones[`SIE_BIT_PLL_LOCK_TO];
		set_hit = set_wr ? wr_ones : 32'h0000_0000;
	end

	always_comb begin
		en_nxt = (en_r & ~clr_hit) | set_hit;
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			en_r <= `SIE_EN_RESET;
		end else begin
			en_r <= en_nxt;
		end
	end

	// ======================================================================
	// Interrupt flags
	// A source edge in the same cycle as a write-one clear keeps the flag,
	// so no event is lost to a racing software acknowledge.
	logic [31:0] flag_nxt;

	always_comb begin
		flag_nxt = flag_r;
		if (commit && hit_flag) begin
			flag_nxt = flag_nxt & ~wr_ones;
		end
		flag_nxt = flag_nxt | (src_rise & `SIE_IMPL_MASK);
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flag_r <= `SIE_FLAG_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// ======================================================================
	// Per-source pending view
	// Named terms keep each source traceable through the request tree.
	logic xtal_ready_en;
	logic xtal32k_ready_en;
	logic rc32k_ready_en;
	logic rc8m_ready_en;
	logic fll_ready_en;
	logic fll_out_of_bounds_en;
	logic fll_fine_lock_en;
	logic fll_coarse_lock_en;
	logic fll_ref_clock_stopped_en;
	logic brownout_ready_en;
	logic brownout_detect_en;
	logic brownout_sync_ready_en;
	logic pll_lock_rise_en;
	logic pll_lock_fall_en;
	logic pll_lock_timeout_en;
	logic pend_xtal_ready;
	logic pend_xtal32k_ready;
	logic pend_rc32k_ready;
	logic pend_rc8m_ready;
	logic pend_fll_ready;
	logic pend_fll_out_of_bounds;
	logic pend_fll_fine_lock;
	logic pend_fll_coarse_lock;
	logic pend_fll_ref_clock_stopped;
	logic pend_brownout_ready;
	logic pend_brownout_detect;
	logic pend_brownout_sync_ready;
	logic pend_pll_lock_rise;
	logic pend_pll_lock_fall;
	logic pend_pll_lock_timeout;

	assign xtal_ready_en            = en_r[`SIE_BIT_XTAL_RDY];
	assign xtal32k_ready_en         = en_r[`SIE_BIT_XTAL32K_RDY];
	assign rc32k_ready_en           = en_r[`SIE_BIT_RC32K_RDY];
	assign rc8m_ready_en            = en_r[`SIE_BIT_RC8M_RDY];
	assign fll_ready_en             = en_r[`SIE_BIT_FLL_RDY];
	assign fll_out_of_bounds_en     = en_r[`SIE_BIT_FLL_OOB];
	assign fll_fine_lock_en         = en_r[`SIE_BIT_FLL_FINE];
	assign fll_coarse_lock_en       = en_r[`SIE_BIT_FLL_COARSE];
	assign fll_ref_clock_stopped_en = en_r[`SIE_BIT_FLL_REFSTOP];
	assign brownout_ready_en        = en_r[`SIE_BIT_BOD_RDY];
	assign brownout_detect_en       = en_r[`SIE_BIT_BOD_DET];
	assign brownout_sync_ready_en   = en_r[`SIE_BIT_BOD_SYNC_RDY];
	assign pll_lock_rise_en         = en_r[`SIE_BIT_PLL_LOCK_RISE];
	assign pll_lock_fall_en         = en_r[`SIE_BIT_PLL_LOCK_FALL];
	assign pll_lock_timeout_en      = en_r[`SIE_BIT_PLL_LOCK_TO];

	assign pend_xtal_ready            = xtal_ready_en & flag_r[`SIE_BIT_XTAL_RDY];
	assign pend_xtal32k_ready         = xtal32k_ready_en & flag_r[`SIE_BIT_XTAL32K_RDY];
	assign pend_rc32k_ready           = rc32k_ready_en & flag_r[`SIE_BIT_RC32K_RDY];
	assign pend_rc8m_ready            = rc8m_ready_en & flag_r[`SIE_BIT_RC8M_RDY];
	assign pend_fll_ready             = fll_ready_en & flag_r[`SIE_BIT_FLL_RDY];
	assign pend_fll_out_of_bounds     = fll_out_of_bounds_en & flag_r[`SIE_BIT_FLL_OOB];
	assign pend_fll_fine_lock         = fll_fine_lock_en & flag_r[`SIE_BIT_FLL_FINE];
	assign pend_fll_coarse_lock       = fll_coarse_lock_en & flag_r[`SIE_BIT_FLL_COARSE];
	assign pend_fll_ref_clock_stopped = fll_ref_clock_stopped_en & flag_r[`SIE_BIT_FLL_REFSTOP];
	assign pend_brownout_ready        = brownout_ready_en & flag_r[`SIE_BIT_BOD_RDY];
	assign pend_brownout_detect       = brownout_detect_en & flag_r[`SIE_BIT_BOD_DET];
	assign pend_brownout_sync_ready   = brownout_sync_ready_en & flag_r[`SIE_BIT_BOD_SYNC_RDY];
	assign pend_pll_lock_rise         = pll_lock_rise_en & flag_r[`SIE_BIT_PLL_LOCK_RISE];
	assign pend_pll_lock_fall         = pll_lock_fall_en & flag_r[`SIE_BIT_PLL_LOCK_FALL];
	assign pend_pll_lock_timeout      = pll_lock_timeout_en & flag_r[`SIE_BIT_PLL_LOCK_TO];

	// ======================================================================
	// Interrupt request
	logic irq_r;
	logic irq_nxt;

	always_comb begin
		irq_nxt = pend_xtal_ready
			| pend_xtal32k_ready
			| pend_rc32k_ready
			| pend_rc8m_ready
			| pend_fll_ready
			| pend_fll_out_of_bounds
			| pend_fll_fine_lock
			| pend_fll_coarse_lock
			| pend_fll_ref_clock_stopped
			| pend_brownout_ready
			| pend_brownout_detect
			| pend_brownout_sync_ready
			| pend_pll_lock_rise
			| pend_pll_lock_fall
			| pend_pll_lock_timeout;
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ======================================================================
	// Outputs
	assign avs_waitrequest = rsp_r.waitrequest;
	assign avs_readdata    = rsp_r.readdata;
	assign avs_response    = rsp_r.response;
	assign irq             = irq_r;

endmodule // sie_irq_enable_clear
`default_nettype wire

//--- sie_irq_enable_clear_checker.sv
// Concurrent checks on the ports of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
`include "sie_defines.svh"
module sie_irq_enable_clear_checker (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic [`SIE_ADDR_W-1:0]  avs_address,
	input wire logic                    avs_write,
	input wire logic                    avs_read,
	input wire logic [3:0]              avs_byteenable,
	input wire logic [31:0]             avs_writedata,
	input wire logic                    avs_waitrequest,
	input wire logic [31:0]             avs_readdata,
	input wire logic [1:0]              avs_response,
	input wire logic                    write_lock,
	input wire logic                    irq
);
	logic [31:0] en_r, en_nxt, wm;
	logic        ans, ok;
	// ====
	// Shadow of the enables; a locked write must leave it alone.
	always_comb begin
		ans = !avs_waitrequest;
		ok = ans && avs_write && !write_lock;
		wm = avs_writedata & `SIE_IMPL_MASK & {{8{avs_byteenable[3]}},
			{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		en_nxt = en_r;
		if (ok && avs_address == 4'h0)
			en_nxt = en_r & ~wm;
		if (ok && avs_address == 4'h4)
			en_nxt = en_r | wm;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			en_r <= 32'h0;
		else
			en_r <= en_nxt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_mask_readback: assert property (ans && avs_read && avs_address[1:0] == 2'h0
		&& !avs_address[3] |-> avs_readdata == en_r) else $error("enable readback differs");
	a_masked_quiet: assert property ($past(en_r) == 32'h0 |-> !irq)
		else $error("irq high with no enable");
	a_one_wait: assert property (ans |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_answer_bound: assert property ($rose(avs_read || avs_write) |-> ##[1:4] ans)
		else $error("no answer in time");
	a_unmapped_err: assert property (ans && avs_address[1:0] != 2'h0
		|-> avs_response == 2'h3) else $error("unmapped not decode error");
	a_locked_refused: assert property (ans && avs_write && write_lock
		&& avs_address[1:0] == 2'h0 |-> avs_response == 2'h2) else $error("locked write okay");
	a_pending_ro: assert property (ans && avs_write && avs_address == 4'hC
		|-> avs_response == 2'h2) else $error("pending write okay");
	a_pending_masked: assert property (ans && avs_read && avs_address == 4'hC
		|-> (avs_readdata & ~en_r) == 32'h0) else $error("pending beyond enables");
	a_pending_irq: assert property (ans && avs_read && avs_address == 4'hC
		|-> irq == (avs_readdata != 32'h0)) else $error("irq differs from pending");
	c_clear_write: cover property (ok && avs_address == 4'h0);
	c_irq_up: cover property ($rose(irq));
	c_locked: cover property (ans && avs_write && write_lock);
endmodule // sie_irq_enable_clear_checker
bind sie_irq_enable_clear sie_irq_enable_clear_checker u_chk (.clk(clk), .nrst(nrst),
	.avs_address(avs_address), .avs_write(avs_write), .avs_read(avs_read),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.avs_response(avs_response), .write_lock(write_lock), .irq(irq));
`default_nettype wire

//--- sie_pkg.sv
// Types shared by the interrupt enable block.
package sie_pkg;

	// ======================================================================
	// Bus sequencer states, Gray coded along idle to answer
	typedef enum logic [1:0] {
		SIE_ST_IDLE = 2'h0,
		SIE_ST_ANSWER = 2'h1
	} sie_bus_state_e;

	// ======================================================================
	// One Avalon-MM request as seen by the slave
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} sie_avm_req_s;

	// ======================================================================
	// The answer the slave drives back
	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
		logic [1:0]  response;
	} sie_avm_rsp_s;

endpackage

//--- test_sie_irq_enable_clear.sv
// Self-checking testbench of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
`include "sie_defines.svh"
module test_sie_irq_enable_clear;
	logic clk, nrst, write_lock, go, done, waitrequest, irq;
	logic [17:0] src_level;
	logic [31:0] readdata, rdata, en_m, d;
	logic [1:0]  response, rresp;
	logic [3:0]  a, be;
	sie_pkg::sie_avm_req_s cmd, bus;
	int err_count, checks_done, seed, cyc, i;
	sie_irq_enable_clear u_sie_irq_enable_clear (.clk(clk), .nrst(nrst),
		.avs_address(bus.address), .avs_read(bus.read), .avs_write(bus.write),
		.avs_byteenable(bus.byteenable), .avs_writedata(bus.writedata),
		.avs_waitrequest(waitrequest), .avs_readdata(readdata), .avs_response(response),
		.write_lock(write_lock), .src_level(src_level), .irq(irq));
	sie_avm_master u_sie_avm_master (.clk(clk), .go(go), .cmd(cmd), .waitrequest(waitrequest),
		.readdata(readdata), .response(response), .bus(bus), .done(done), .rdata(rdata),
		.rresp(rresp));
	always #20 clk = ~clk;
	task results;
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task xfer(input logic w, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] bl);
		@(posedge clk);
		cmd <= '{address: ad, read: !w, write: w, byteenable: bl, writedata: wd};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (done !== 1'b1);
	endtask
	function automatic logic [31:0] upd(logic [31:0] e, logic [3:0] ad, logic [31:0] wd,
		logic [3:0] bl);
		logic [31:0] m;
		m = wd & `SIE_IMPL_MASK & {{8{bl[3]}}, {8{bl[2]}}, {8{bl[1]}}, {8{bl[0]}}};
		return (ad == 4'h0) ? (e & ~m) : (e | m);
	endfunction
	initial begin
		clk = 1'b0; nrst = 1'b0; write_lock = 1'b0; src_level = '0; go = 1'b0; cmd = '0;
		err_count = 0; checks_done = 0; seed = 98; cyc = 0; en_m = 32'h0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 16; i += 4) begin
			xfer(1'b0, i[3:0], 32'h0, 4'hF);
			chk(rdata, 32'h0);
		end
		xfer(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
		en_m = upd(en_m, 4'h4, 32'hFFFF_FFFF, 4'hF);
		for (i = 0; i < 18; i++) begin
			xfer(1'b1, 4'h0, 32'h1 << i, 4'hF);
			xfer(1'b1, 4'h0, 32'h0, 4'hF);
			en_m = upd(en_m, 4'h0, 32'h1 << i, 4'hF);
			xfer(1'b0, 4'h0, 32'h0, 4'hF);
			chk(rdata, en_m);
		end
		repeat (30) begin
			a = ($random(seed) & 1) ? 4'h4 : 4'h0;
			d = $random(seed);
			be = $random(seed);
			src_level <= $random(seed);
			xfer(1'b1, a, d, be);
			en_m = upd(en_m, a, d, be);
			xfer(1'b0, 4'h4 - a, 32'h0, 4'hF);
			chk(rdata, en_m);
		end
		src_level <= '0;
		xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
		repeat (6) @(posedge clk);
		xfer(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
		src_level <= 18'h00400;
		repeat (8) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 4'h4, 32'h400, 4'hF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b0, 4'hC, 32'h0, 4'hF);
		chk(rdata, 32'h400);
		xfer(1'b1, 4'h0, 32'h400, 4'hF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 4'h4, 32'h400, 4'hF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		write_lock <= 1'b1;
		xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
		chk({30'h0, rresp}, 32'h2);
		write_lock <= 1'b0;
		xfer(1'b0, 4'h0, 32'h0, 4'hF);
		chk(rdata, 32'h400);
		xfer(1'b0, 4'h2, 32'h0, 4'hF);
		chk({30'h0, rresp}, 32'h3);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		xfer(1'b0, 4'h4, 32'h0, 4'hF);
		chk(rdata, 32'h0);
		chk({31'h0, irq}, 32'h0);
		results();
	end
endmodule // test_sie_irq_enable_clear
`default_nettype wire
